// File: logic/rxp_sample_port.sv
// Receive sample port: clock-crossing FIFO and link-side output logic.
`timescale 1ns/10ps
`include "rxp_defs.svh"

// ****************************************
// Dual-clock FIFO with gray-coded pointers.
// ****************************************
module rxp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  // Write side.
  input  wire logic             i_wclk,
  input  wire logic             i_rstn,
  input  wire logic             i_wvalid,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic                  o_wready,
  // Read side.
  input  wire logic             i_rclk,
  output logic                  o_rvalid,
  output logic      [WIDTH-1:0] o_rdata,
  input  wire logic             i_rready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin;
  logic [AW:0]      wgray;
  logic [AW:0]      rbin;
  logic [AW:0]      rgray;
  logic [AW:0]      rq1;
  logic [AW:0]      rq2;
  logic [AW:0]      wq1;
  logic [AW:0]      wq2;
  logic             wready;
  logic             rempty;
  logic             push;
  logic             pop;
  logic [AW:0]      next_wbin;
  logic [AW:0]      next_wgray;
  logic [AW:0]      next_rbin;
  logic [AW:0]      next_rgray;

  assign push       = i_wvalid && wready;
  assign pop        = i_rready && !rempty;
  assign next_wbin  = wbin + {{AW{1'b0}}, push};
  assign next_wgray = (next_wbin >> 1) ^ next_wbin;
  assign next_rbin  = rbin + {{AW{1'b0}}, pop};
  assign next_rgray = (next_rbin >> 1) ^ next_rbin;
  assign o_wready   = wready;
  assign o_rvalid   = !rempty;
  assign o_rdata    = mem[rbin[AW-1:0]];

  always_ff @(posedge i_wclk) begin
    if (push) begin
      mem[wbin[AW-1:0]] <= i_wdata;
    end
  end

  always_ff @(posedge i_wclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wbin  <= '0;
      wgray <= '0;
      rq1   <= '0;
      rq2   <= '0;
      wready <= 1'b1;
    end else begin
      wbin  <= next_wbin;
      wgray <= next_wgray;
      rq1   <= rgray;
      rq2   <= rq1;
      wready <= next_wgray != {~rq2[AW:AW-1], rq2[AW-2:0]};
    end
  end

  always_ff @(posedge i_rclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rbin   <= '0;
      rgray  <= '0;
      wq1    <= '0;
      wq2    <= '0;
      rempty <= 1'b1;
    end else begin
      rbin   <= next_rbin;
      rgray  <= next_rgray;
      wq1    <= wgray;
      wq2    <= wq1;
      rempty <= next_rgray == wq2;
    end
  end
endmodule // rxp_fifo

module rxp_sample_port (
  // Clocks and reset.
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_clk_link,
  input  wire logic                     i_rstn,
  // Converter samples.
  input  wire logic [`RXP_SAMPLE_W-1:0] i_rx_i_sample,
  input  wire logic [`RXP_SAMPLE_W-1:0] i_rx_q_sample,
  input  wire logic                     i_rx_sample_valid,
  output logic                          o_rx_sample_ready,
  // Rate change status.
  input  wire logic                     i_rx_decim_active,
  input  wire logic                     i_tx_interp_active,
  // Register port.
  input  wire logic                     i_reg_wr,
  input  wire logic [`RXP_ADDR_W-1:0]   i_reg_addr,
  input  wire logic [`RXP_REG_W-1:0]    i_reg_wdata,
  output logic      [`RXP_REG_W-1:0]    o_reg_rdata,
  output logic                          o_rx_doubler_active,
  output logic                          o_tx_doubler_active,
  // Mode pins.
  input  wire logic                     i_half_duplex,
  input  wire logic                     i_tx_direction,
  input  wire logic                     i_rx_clock_invert,
  input  wire logic                     i_rx_pair_order,
  input  wire logic                     i_rx_flag_polarity,
  input  wire logic                     i_rx_ddr_mode,
  input  wire logic                     i_rx_single_adc,
  input  wire logic                     i_rx_single_q,
  input  wire logic                     i_rx_number_format,
  // Shared sample port.
  input  wire logic [`RXP_SAMPLE_W-1:0] i_rx_sample_bus,
  output logic      [`RXP_SAMPLE_W-1:0] o_rx_sample_bus,
  output logic                          o_rx_sample_bus_oe_n,
  input  wire logic                     i_rx_channel_flag,
  output logic                          o_rx_channel_flag,
  output logic                          o_rx_channel_flag_oe_n,
  output logic                          o_rx_output_clock,
  output logic      [`RXP_SAMPLE_W:0]   o_hd_tx_word,
  output logic                          o_tx_port_enable
);
  localparam int SW = `RXP_SAMPLE_W;

  // ****************************************
  // Configuration registers.
  // ****************************************
  logic [`RXP_REG_W-1:0] doubler_select;
  logic [`RXP_REG_W-1:0] doubler_operating_point_a;
  logic [`RXP_REG_W-1:0] doubler_operating_point_b;
  logic [`RXP_REG_W-1:0] doubler_operating_point_c;
  logic [`RXP_REG_W-1:0] doubler_pulse_width;
  logic [`RXP_REG_W-1:0] output_drive_strength;
  logic [`RXP_REG_W-1:0] next_rdata;
  logic                  ddr_s1;
  logic                  ddr_s2;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      doubler_select            <= `RXP_RST_REG;
      doubler_operating_point_a <= `RXP_RST_REG;
      doubler_operating_point_b <= `RXP_RST_REG;
      doubler_operating_point_c <= `RXP_RST_REG;
      doubler_pulse_width       <= `RXP_RST_REG;
      output_drive_strength     <= `RXP_RST_REG;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `RXP_OFF_DBL_SEL) begin
        doubler_select <= i_reg_wdata;
      end else if (i_reg_addr == `RXP_OFF_OP_A) begin
        doubler_operating_point_a <= i_reg_wdata;
      end else if (i_reg_addr == `RXP_OFF_OP_B) begin
        doubler_operating_point_b <= i_reg_wdata;
      end else if (i_reg_addr == `RXP_OFF_OP_C) begin
        doubler_operating_point_c <= i_reg_wdata;
      end else if (i_reg_addr == `RXP_OFF_DBL_PW) begin
        doubler_pulse_width <= i_reg_wdata;
      end else if (i_reg_addr == `RXP_OFF_DRIVE) begin
        output_drive_strength <= i_reg_wdata;
      end
    end
  end

  always_comb begin
    if (i_reg_addr == `RXP_OFF_DBL_SEL) begin
      next_rdata = doubler_select;
    end else if (i_reg_addr == `RXP_OFF_OP_A) begin
      next_rdata = doubler_operating_point_a;
    end else if (i_reg_addr == `RXP_OFF_OP_B) begin
      next_rdata = doubler_operating_point_b;
    end else if (i_reg_addr == `RXP_OFF_OP_C) begin
      next_rdata = doubler_operating_point_c;
    end else if (i_reg_addr == `RXP_OFF_DBL_PW) begin
      next_rdata = doubler_pulse_width;
    end else if (i_reg_addr == `RXP_OFF_DRIVE) begin
      next_rdata = output_drive_strength;
    end else begin
      next_rdata = `RXP_RST_REG;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata         <= `RXP_RST_REG;
      ddr_s1              <= 1'b0;
      ddr_s2              <= 1'b0;
      o_rx_doubler_active <= 1'b0;
      o_tx_doubler_active <= 1'b0;
    end else begin
      o_reg_rdata         <= next_rdata;
      ddr_s1              <= i_rx_ddr_mode;
      ddr_s2              <= ddr_s1;
      o_rx_doubler_active <= doubler_select[`RXP_BIT_RX_DBL] && !ddr_s2
                             && !i_rx_decim_active;
      o_tx_doubler_active <= doubler_select[`RXP_BIT_TX_DBL] && !ddr_s2
                             && !i_tx_interp_active;
    end
  end

  // ****************************************
  // Sample buffer into the link domain.
  // ****************************************
  logic              fifo_rvalid;
  logic [2*SW-1:0]   fifo_rdata;
  logic              pop;

  rxp_fifo #(.WIDTH(2*SW), .DEPTH(`RXP_FIFO_DEPTH)) u_fifo (
    .i_wclk   (i_clk_sys),
    .i_rstn   (i_rstn),
    .i_wvalid (i_rx_sample_valid),
    .i_wdata  ({i_rx_q_sample, i_rx_i_sample}),
    .o_wready (o_rx_sample_ready),
    .i_rclk   (i_clk_link),
    .o_rvalid (fifo_rvalid),
    .o_rdata  (fifo_rdata),
    .i_rready (pop)
  );

  // ****************************************
  // Link-side output logic.
  // ****************************************
  logic [`RXP_MODE_W-1:0] mode_s1;
  logic [`RXP_MODE_W-1:0] mode_s2;
  logic [SW:0]            hd_s1;
  logic [SW:0]            hd_s2;
  logic                   m_hd;
  logic                   m_txdir;
  logic                   m_inv;
  logic                   m_order;
  logic                   m_pol;
  logic                   m_ddr;
  logic                   m_single;
  logic                   m_selq;
  logic                   m_fmt;
  logic                   half;
  logic                   raw_clk;
  logic                   next_raw_clk;
  rxp_pkg::rxp_slot_t     slot;
  logic [SW-1:0]          hold;
  logic                   hold_is_i;
  logic                   rx_drive;
  logic                   go;
  logic [SW-1:0]          first_w;
  logic [SW-1:0]          word;
  logic                   word_is_i;

  assign {m_hd, m_txdir, m_inv, m_order, m_pol, m_ddr, m_single, m_selq,
          m_fmt} = mode_s2;
  assign rx_drive = !m_hd || !m_txdir;
  assign first_w  = m_order ? fifo_rdata[SW-1:0] : fifo_rdata[2*SW-1:SW];
  assign go = !half && rx_drive
              && (fifo_rvalid || (slot == rxp_pkg::RXP_SECOND));
  assign pop = go && (m_single || slot == rxp_pkg::RXP_FIRST);
  assign next_raw_clk = m_ddr ? (raw_clk ^ go) : go;

  always_comb begin
    word      = hold;
    word_is_i = hold_is_i;
    if (m_single) begin
      word      = m_selq ? fifo_rdata[2*SW-1:SW] : fifo_rdata[SW-1:0];
      word_is_i = !m_selq;
    end else if (slot == rxp_pkg::RXP_FIRST) begin
      word      = first_w;
      word_is_i = m_order;
    end
  end

  always_ff @(posedge i_clk_link or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_s1 <= '0;
      mode_s2 <= '0;
      hd_s1   <= '0;
      hd_s2   <= '0;
    end else begin
      mode_s1 <= {i_half_duplex, i_tx_direction, i_rx_clock_invert,
                  i_rx_pair_order, i_rx_flag_polarity, i_rx_ddr_mode,
                  i_rx_single_adc, i_rx_single_q, i_rx_number_format};
      mode_s2 <= mode_s1;
      hd_s1   <= {i_rx_channel_flag, i_rx_sample_bus};
      hd_s2   <= hd_s1;
    end
  end

  always_ff @(posedge i_clk_link or negedge i_rstn) begin
    if (!i_rstn) begin
      half      <= 1'b0;
      raw_clk   <= 1'b0;
      slot      <= rxp_pkg::RXP_FIRST;
      hold      <= '0;
      hold_is_i <= 1'b0;
    end else begin
      half    <= !half;
      raw_clk <= next_raw_clk;
      if (go && !m_single) begin
        case (slot)
          rxp_pkg::RXP_FIRST: begin
            slot      <= rxp_pkg::RXP_SECOND;
            hold      <= m_order ? fifo_rdata[2*SW-1:SW]
                                 : fifo_rdata[SW-1:0];
            hold_is_i <= !m_order;
          end
          default: begin
            slot <= rxp_pkg::RXP_FIRST;
          end
        endcase
      end else if (m_single) begin
        slot <= rxp_pkg::RXP_FIRST;
      end
    end
  end

  always_ff @(posedge i_clk_link or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rx_output_clock      <= 1'b0;
      o_rx_sample_bus        <= '0;
      o_rx_channel_flag      <= 1'b0;
      o_rx_sample_bus_oe_n   <= 1'b0;
      o_rx_channel_flag_oe_n <= 1'b0;
      o_hd_tx_word           <= '0;
      o_tx_port_enable       <= 1'b1;
    end else begin
      o_rx_output_clock      <= next_raw_clk ^ m_inv;
      o_rx_sample_bus_oe_n   <= !rx_drive;
      o_rx_channel_flag_oe_n <= !rx_drive;
      o_tx_port_enable       <= !m_hd;
      if (!rx_drive) begin
        o_hd_tx_word <= hd_s2;
      end
      if (go) begin
        o_rx_sample_bus   <= {word[SW-1] ^ m_fmt, word[SW-2:0]};
        o_rx_channel_flag <= m_pol ~^ word_is_i;
      end
    end
  end

  // ****************************************
  // Checks.
  // ****************************************
  a_launch_edge: assert property (@(posedge i_clk_link) disable iff (!i_rstn)
    go && !m_ddr |=> o_rx_output_clock == !$past(m_inv))
    else $error("Word not launched on the active clock edge.");
  a_sdr_fall: assert property (@(posedge i_clk_link) disable iff (!i_rstn)
    go && !m_ddr && $stable(m_inv) |=> ##1 o_rx_output_clock == $past(m_inv, 2))
    else $error("Bus rate clock did not return to idle.");
  a_ddr_toggle: assert property (@(posedge i_clk_link) disable iff (!i_rstn)
    go && m_ddr && $stable(m_inv) |=> o_rx_output_clock != $past(o_rx_output_clock))
    else $error("Double rate clock did not toggle with a word.");
  a_single_flag: assert property (@(posedge i_clk_link) disable iff (!i_rstn)
    go && m_single |=> o_rx_channel_flag == ($past(m_pol) ~^ !$past(m_selq)))
    else $error("Flag does not show the active converter.");
  a_pair_flag: assert property (@(posedge i_clk_link) disable iff (!i_rstn)
    go && !m_single && slot == rxp_pkg::RXP_FIRST
    |=> o_rx_channel_flag == ($past(m_pol) ~^ $past(m_order)))
    else $error("First word of a pair carries the wrong flag.");
  a_format_msb: assert property (@(posedge i_clk_link) disable iff (!i_rstn)
    go && !m_single && slot == rxp_pkg::RXP_FIRST
    |=> o_rx_sample_bus[SW-1] == ($past(first_w[SW-1]) ^ $past(m_fmt)))
    else $error("Sign bit not coded in the selected format.");
  a_bus_release: assert property (@(posedge i_clk_link) disable iff (!i_rstn)
    !rx_drive |=> o_rx_sample_bus_oe_n && o_rx_channel_flag_oe_n
                  && $stable(o_rx_sample_bus))
    else $error("Bus driven while the shared port receives.");
  a_tx_port_off: assert property (@(posedge i_clk_link) disable iff (!i_rstn)
    $past(mode_s2[`RXP_MODE_W-1]) |-> !o_tx_port_enable)
    else $error("Transmit port left on in half duplex.");
  a_doubler_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ddr_s2 || i_rx_decim_active |=> !o_rx_doubler_active)
    else $error("Receive doubler on outside single rate.");
  c_pair_out: cover property (@(posedge i_clk_link) disable iff (!i_rstn)
    go && slot == rxp_pkg::RXP_SECOND);
  c_ddr_word: cover property (@(posedge i_clk_link) disable iff (!i_rstn)
    go && m_ddr);
  c_fifo_full: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_rx_sample_valid && !o_rx_sample_ready);
endmodule // rxp_sample_port

// File: logic/rxp_defs.svh
// Register offsets, reset values and widths of the receive sample port.
`ifndef RXP_DEFS_SVH
`define RXP_DEFS_SVH
`define RXP_SAMPLE_W     12
`define RXP_FIFO_DEPTH   32
`define RXP_ADDR_W       7
`define RXP_REG_W        8
`define RXP_OFF_DBL_SEL  7'h39
`define RXP_OFF_OP_A     7'h3a
`define RXP_OFF_OP_B     7'h3b
`define RXP_OFF_OP_C     7'h3c
`define RXP_OFF_DBL_PW   7'h3e
`define RXP_OFF_DRIVE    7'h63
`define RXP_RST_REG      8'h00
`define RXP_BIT_TX_DBL   0
`define RXP_BIT_RX_DBL   1
`define RXP_MODE_W       9
`endif

// File: logic/rxp_pkg.sv
// Types shared by the receive sample port.
package rxp_pkg;
  typedef enum logic {RXP_FIRST, RXP_SECOND} rxp_slot_t;
endpackage

// File: verification/rxp_baseband_model.sv
// Baseband receiver model that captures words from the shared sample port.
`timescale 1ns/10ps
`include "rxp_defs.svh"

module rxp_baseband_model (
  // Link clock and capture settings.
  input  wire logic                     i_clk_link,
  input  wire logic                     i_inv,
  input  wire logic                     i_ddr,
  input  wire logic [`RXP_SAMPLE_W:0]   i_tx_word,
  // Device pins.
  input  wire logic [`RXP_SAMPLE_W-1:0] i_bus,
  input  wire logic                     i_flag,
  input  wire logic                     i_bus_oe_n,
  input  wire logic                     i_flag_oe_n,
  input  wire logic                     i_oclk,
  // Wire levels fed back to the device.
  output logic      [`RXP_SAMPLE_W-1:0] o_bus,
  output logic                          o_flag
);
  logic [12:0] words[$];
  logic        prev_clk = 1'b0;
  int          cnt = 0;
  int          gap = 0;

  // ****************************************
  // Capture on every launching clock edge.
  // ****************************************
  always @(posedge i_clk_link) begin
    prev_clk <= i_oclk;
    cnt <= (i_oclk !== prev_clk) ? 1 : cnt + 1;
    if (i_oclk !== prev_clk) begin
      gap <= cnt;
      if (i_ddr || i_oclk === ~i_inv) begin
        words.push_back({i_flag, i_bus});
      end
    end
  end

  // The model drives the port only while the device has let it go.
  assign o_bus  = i_bus_oe_n ? i_tx_word[11:0] : i_bus;
  assign o_flag = i_flag_oe_n ? i_tx_word[12] : i_flag;
endmodule // rxp_baseband_model

// File: verification/rxp_sample_port_test.sv
// Self-checking bench for the receive sample port.
`timescale 1ns/10ps
`include "rxp_defs.svh"

module rxp_sample_port_test;
  // ****************
  // Signals.
  // ****************
  logic        clk_sys = 1'b0;
  logic        clk_link = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] si = 12'h000;
  logic [11:0] sq = 12'h000;
  logic        sv = 1'b0;
  logic        decim = 1'b0;
  logic        interp = 1'b0;
  logic        wr = 1'b0;
  logic [6:0]  addr = 7'h00;
  logic [7:0]  wdata = 8'h00;
  logic        hd = 1'b0;
  logic        txdir = 1'b0;
  logic        inv = 1'b0;
  logic        ord = 1'b1;
  logic        pol = 1'b1;
  logic        ddr = 1'b0;
  logic        sgl = 1'b0;
  logic        selq = 1'b0;
  logic        fmt = 1'b0;
  logic [12:0] tx_word = 13'h1a5c;
  logic [11:0] bus_in;
  logic [11:0] bus;
  logic        flag_in;
  logic        ready, dbl_rx, dbl_tx, bus_oe_n, flag_oe_n, oclk, flag, tx_en;
  logic [7:0]  rdata;
  logic [12:0] hd_word;
  logic [12:0] xq[$];
  int          err_count = 0;
  int          cmp_count = 0;

  always #2.5 clk_sys = ~clk_sys;
  always #6 clk_link = ~clk_link;

  rxp_sample_port i_rxp_sample_port (
    .i_clk_sys(clk_sys), .i_clk_link(clk_link), .i_rstn(rstn),
    .i_rx_i_sample(si), .i_rx_q_sample(sq), .i_rx_sample_valid(sv),
    .o_rx_sample_ready(ready), .i_rx_decim_active(decim),
    .i_tx_interp_active(interp), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_rx_doubler_active(dbl_rx), .o_tx_doubler_active(dbl_tx),
    .i_half_duplex(hd), .i_tx_direction(txdir), .i_rx_clock_invert(inv),
    .i_rx_pair_order(ord), .i_rx_flag_polarity(pol), .i_rx_ddr_mode(ddr),
    .i_rx_single_adc(sgl), .i_rx_single_q(selq),
    .i_rx_number_format(fmt), .i_rx_sample_bus(bus_in),
    .o_rx_sample_bus(bus), .o_rx_sample_bus_oe_n(bus_oe_n),
    .i_rx_channel_flag(flag_in), .o_rx_channel_flag(flag),
    .o_rx_channel_flag_oe_n(flag_oe_n), .o_rx_output_clock(oclk),
    .o_hd_tx_word(hd_word), .o_tx_port_enable(tx_en));

  rxp_baseband_model i_rxp_baseband_model (
    .i_clk_link(clk_link), .i_inv(inv), .i_ddr(ddr), .i_tx_word(tx_word),
    .i_bus(bus), .i_flag(flag), .i_bus_oe_n(bus_oe_n),
    .i_flag_oe_n(flag_oe_n), .i_oclk(oclk), .o_bus(bus_in),
    .o_flag(flag_in));

  // ****************
  // Helpers.
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_sys);
    wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    @(negedge clk_sys);
    chk(16'(rdata), 16'(d));
  endtask

  task automatic settle();
    repeat (20) @(negedge clk_sys);
  endtask

  function automatic logic [11:0] pat_i(input int k);
    return 12'h805 + 12'(k) * 12'h123;
  endfunction

  function automatic logic [11:0] pat_q(input int k);
    return 12'h3fa - 12'(k) * 12'h0b7;
  endfunction

  function automatic logic [12:0] exp_w(input logic [11:0] s, input logic i);
    return {pol ~^ i, fmt ? {~s[11], s[10:0]} : s};
  endfunction

  task automatic push(input int k);
    int w;
    w = 0;
    if (sgl) xq.push_back(selq ? exp_w(pat_q(k), 0) : exp_w(pat_i(k), 1));
    else if (ord) xq.push_back(exp_w(pat_i(k), 1));
    if (!sgl) xq.push_back(exp_w(pat_q(k), 0));
    if (!sgl && !ord) xq.push_back(exp_w(pat_i(k), 1));
    @(negedge clk_sys);
    sv = 1'b1;
    si = pat_i(k);
    sq = pat_q(k);
    while (ready !== 1'b1 && w < 200) begin
      @(negedge clk_sys);
      w++;
    end
    if (w >= 200) err_count++;
    @(posedge clk_sys);
  endtask

  task automatic stream(input int n);
    for (int k = 0; k < n; k++) push(k);
    @(negedge clk_sys);
    sv = 1'b0;
  endtask

  task automatic drain();
    int w;
    w = 0;
    while (i_rxp_baseband_model.words.size() < xq.size() && w < 1000) begin
      @(negedge clk_sys);
      w++;
    end
    settle();
    chk(16'(i_rxp_baseband_model.words.size()), 16'(xq.size()));
    while (xq.size() > 0 && i_rxp_baseband_model.words.size() > 0)
      chk(16'(i_rxp_baseband_model.words.pop_front()), 16'(xq.pop_front()));
    i_rxp_baseband_model.words.delete();
    xq.delete();
  endtask

  // ****************
  // Scenarios.
  // ****************
  task automatic t_reset();
    chk(16'({bus_oe_n, flag_oe_n, oclk, tx_en, ready}), 16'h0003);
    reg_rd(7'h39, 8'h00);
    reg_rd(7'h3a, 8'h00);
    reg_rd(7'h3b, 8'h00);
    reg_rd(7'h3c, 8'h00);
    reg_rd(7'h3e, 8'h00);
    reg_rd(7'h63, 8'h00);
    $display("done reset");
  endtask

  task automatic t_regs();
    reg_wr(7'h3a, 8'h55);
    reg_wr(7'h3b, 8'h55);
    reg_wr(7'h3c, 8'h00);
    reg_wr(7'h3e, 8'h3f);
    reg_wr(7'h63, 8'haa);
    reg_wr(7'h10, 8'hff);
    reg_wr(7'h39, 8'h03);
    reg_rd(7'h3a, 8'h55);
    reg_rd(7'h3b, 8'h55);
    reg_rd(7'h3c, 8'h00);
    reg_rd(7'h3e, 8'h3f);
    reg_rd(7'h63, 8'haa);
    reg_rd(7'h10, 8'h00);
    reg_rd(7'h39, 8'h03);
    settle();
    chk(16'({dbl_rx, dbl_tx}), 16'h3);
    decim = 1'b1;
    settle();
    chk(16'({dbl_rx, dbl_tx}), 16'h1);
    decim = 1'b0;
    interp = 1'b1;
    settle();
    chk(16'({dbl_rx, dbl_tx}), 16'h2);
    interp = 1'b0;
    ddr = 1'b1;
    settle();
    chk(16'({dbl_rx, dbl_tx}), 16'h0);
    ddr = 1'b0;
    $display("done regs");
  endtask

  task automatic t_pairs();
    for (int c = 0; c < 4; c++) begin
      ord = c[0];
      pol = c[1];
      settle();
      stream(3);
      drain();
    end
    chk(16'(tx_en), 16'h1);
    $display("done pairs");
  endtask

  task automatic t_clocking();
    fmt = 1'b1;
    settle();
    stream(4);
    drain();
    chk(16'(i_rxp_baseband_model.gap), 16'h1);
    inv = 1'b1;
    settle();
    chk(16'(oclk), 16'h1);
    stream(4);
    drain();
    inv = 1'b0;
    settle();
    ddr = 1'b1;
    settle();
    stream(4);
    drain();
    chk(16'(i_rxp_baseband_model.gap), 16'h2);
    $display("done clocking");
  endtask

  task automatic t_single();
    sgl = 1'b1;
    for (int c = 0; c < 4; c++) begin
      selq = c[0];
      ddr = c[1];
      settle();
      stream(3);
      drain();
    end
    sgl = 1'b0;
    ddr = 1'b0;
    $display("done single");
  endtask

  task automatic t_fill();
    hd = 1'b1;
    txdir = 1'b1;
    settle();
    chk(16'({bus_oe_n, flag_oe_n, tx_en}), 16'h6);
    stream(`RXP_FIFO_DEPTH);
    repeat (2) @(negedge clk_sys);
    chk(16'(ready), 16'h0);
    chk(16'(hd_word), 16'(tx_word));
    txdir = 1'b0;
    drain();
    hd = 1'b0;
    settle();
    chk(16'({bus_oe_n, tx_en, ready}), 16'h3);
    $display("done fill");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #300000;
    err_count++;
    conclude();
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    settle();
    t_reset();
    t_regs();
    t_pairs();
    t_clocking();
    t_single();
    t_fill();
    conclude();
  end
endmodule // rxp_sample_port_test
